// file: eps_pkg.sv
// Package for the external expansion pin select block: map, codes, layouts
package eps_pkg;

  // Register map
  localparam logic [31:0] EPS_CFG_ADDR = 32'hFFFFF04C;
  localparam int EPS_CFG_W = 4;
  localparam int EPS_CFG_BUS8_BIT = 3;
  localparam logic [7:0] EPS_RST_ROMLESS0 = 8'h07;
  localparam logic [7:0] EPS_RST_ROMLESS1 = 8'h0F;
  localparam logic [7:0] EPS_RST_SINGLE0 = 8'h00;
  localparam logic [7:0] EPS_RST_SINGLE1 = 8'h07;
  localparam logic [7:0] EPS_UNMAPPED_DATA = 8'h00;

  // Operating-mode pin codes (strap encodings)
  localparam logic [3:0] EPS_PINS_ROMLESS0 = 4'h0;
  localparam logic [3:0] EPS_PINS_ROMLESS1 = 4'h1;
  localparam logic [3:0] EPS_PINS_SINGLE0 = 4'hA;
  localparam logic [3:0] EPS_PINS_SINGLE1 = 4'hB;

  // Physical address map, 26-bit
  localparam int EPS_PA_W = 26;
  localparam logic [25:0] EPS_RSV_LO = 26'h1000000;
  localparam logic [25:0] EPS_RSV_HI = 26'h2FFFFFF;
  localparam logic [25:0] EPS_EXT_TOP = 26'h3FFDFFF;
  localparam logic [25:0] EPS_ROM0_LO = 26'h0000000;
  localparam logic [25:0] EPS_ROM0_HI = 26'h00FFFFF;
  localparam logic [25:0] EPS_ROM1_LO = 26'h0100000;
  localparam logic [25:0] EPS_ROM1_HI = 26'h01FFFFF;
  localparam int EPS_EXT_ADDR_W = 24;

  // Chip-select block layout: block index taken from the top physical bits
  localparam int EPS_CS_N = 8;
  localparam int EPS_CS_SHIFT = 23;

  // Address-line pairs: code thresholds for PB4/5, PB6/7, P60/61 .. P66/67
  localparam int EPS_PAIR_N = 6;
  localparam int EPS_PAIR_FIRST_CODE = 2;

  typedef enum {
    EPS_OP_ROMLESS0,
    EPS_OP_ROMLESS1,
    EPS_OP_SINGLE0,
    EPS_OP_SINGLE1
  } eps_opmode_t;

  typedef enum {
    EPS_PH_SYNC0,
    EPS_PH_SYNC1,
    EPS_PH_LOAD,
    EPS_PH_RUN
  } eps_phase_t;

  // Pin function per port: a 1 puts that pin in control mode
  typedef struct packed {
    logic [7:0] port4;
    logic [7:0] port5;
    logic [7:0] porta;
    logic [7:0] portb;
    logic [7:0] port6;
  } eps_pinfn_t;

  // Result of one external access decode
  typedef struct packed {
    logic ext_cycle;
    logic [EPS_CS_N-1:0] cs;
    logic [EPS_EXT_ADDR_W-1:0] addr;
  } eps_acc_t;

endpackage : eps_pkg

// file: eps_pair_sel.sv
// One address-line pin pair, enabled once the function code reaches its threshold
`timescale 1ns/10ps
module eps_pair_sel #(
  parameter int THRESHOLD = 2
) (
  input wire logic [2:0] code_in,
  output logic [1:0] ctrl_out
);
  localparam logic [2:0] THR = 3'(THRESHOLD);

  initial begin
    if (THRESHOLD < 1 || THRESHOLD > 7) begin
      $error("eps_pair_sel threshold out of range");
    end
  end

  always_comb begin
    ctrl_out = (code_in >= THR) ? 2'h3 : 2'h0;
  end
endmodule : eps_pair_sel

// file: eps_top.sv
// External expansion pin select: config register, pin functions, external decode
`timescale 1ns/10ps
module eps_top
  import eps_pkg::*;
#(
  parameter bit ROM_PRESENT = 1'b1,
  parameter int CS_N = EPS_CS_N
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] operating_mode_pins_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_wmask_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic acc_req_in,
  input wire logic [31:0] acc_addr_in,
  output logic ext_cycle_out,
  output logic [CS_N-1:0] chip_select_out,
  output logic [EPS_EXT_ADDR_W-1:0] external_address_lines_out,
  output logic bus16_out,
  output eps_pinfn_t pin_function_out,
  output logic [1:0] operating_mode_out,
  output logic config_ready_out
);

  initial begin
    if (CS_N != EPS_CS_N) begin
      $error("eps_top chip-select count must match the block layout");
    end
  end

  typedef struct packed {
    logic [3:0] pins_s1;
    logic [3:0] pins_s2;
    logic [1:0] phase;
    logic ready;
    logic [1:0] opmode;
    logic [EPS_CFG_W-1:0] pin_function_code;
    logic [7:0] rdata;
    eps_pinfn_t pinfn;
    logic bus16;
    eps_acc_t acc;
  } eps_state_t;

  eps_state_t st_ff;
  eps_state_t nxt_st;

  logic [2:0] code_lo;
  logic bus8;
  logic [2*EPS_PAIR_N-1:0] pair_ctrl;
  logic [EPS_PA_W-1:0] phys;
  logic in_rsv;
  logic in_int;
  logic in_rom;
  logic in_ext_map;
  logic expansion_on;
  logic cfg_hit;
  logic [7:0] wr_merged;
  logic [7:0] cfg_byte;
  logic [EPS_CS_N-1:0] cs_onehot;
  logic [2:0] cs_index;

  assign code_lo = st_ff.pin_function_code[2:0];
  assign bus8 = st_ff.pin_function_code[EPS_CFG_BUS8_BIT];

  // One pair per address-line pair on upper port B and port 6
  genvar gi;
  generate
    for (gi = 0; gi < EPS_PAIR_N; gi++) begin : g_pair
      eps_pair_sel #(
        .THRESHOLD(EPS_PAIR_FIRST_CODE + gi)
      ) u_pair (
        .code_in(code_lo),
        .ctrl_out(pair_ctrl[2*gi +: 2])
      );
    end
  endgenerate

  // Upper address bits are images of the 26-bit space
  assign phys = acc_addr_in[EPS_PA_W-1:0];

  // Reserved hole, never external in any mode
  assign in_rsv = (phys >= EPS_RSV_LO) && (phys <= EPS_RSV_HI);

  // Internal RAM and peripheral I/O sit above the external top
  assign in_int = (phys > EPS_EXT_TOP);

  // Internal ROM location depends on mode; ROMless parts have none
  always_comb begin
    in_rom = 1'b0;
    if (ROM_PRESENT) begin
      if (st_ff.opmode == 2'(EPS_OP_SINGLE0)) begin
        in_rom = (phys <= EPS_ROM0_HI);
      end else if (st_ff.opmode == 2'(EPS_OP_SINGLE1)) begin
        in_rom = (phys >= EPS_ROM1_LO) && (phys <= EPS_ROM1_HI);
      end
    end
  end

  // ROMless modes leave the whole low range external
  assign in_ext_map = !in_rsv && !in_int && !in_rom;

  // External cycles need the pins in control mode
  assign expansion_on = (code_lo != 3'h0);

  // Block select; 8 blocks of 8 MB reach the 32 MB usable area and beyond
  assign cs_index = phys[EPS_CS_SHIFT +: 3];
  always_comb begin
    cs_onehot = '0;
    cs_onehot[cs_index] = 1'b1;
  end

  // Low address bit is not decoded, as for the other peripheral registers
  assign cfg_hit = (reg_addr_in[31:1] == EPS_CFG_ADDR[31:1]);
  assign cfg_byte = {4'h0, st_ff.pin_function_code};
  assign wr_merged = (cfg_byte & ~reg_wmask_in) | (reg_wdata_in & reg_wmask_in);

  always_comb begin
    nxt_st = st_ff;

    // Strap sampling; first stage feeds only the second
    nxt_st.pins_s1 = operating_mode_pins_in;
    nxt_st.pins_s2 = st_ff.pins_s1;

    case (eps_phase_t'(st_ff.phase))
      EPS_PH_SYNC0: begin
        nxt_st.phase = 2'(EPS_PH_SYNC1);
      end
      EPS_PH_SYNC1: begin
        nxt_st.phase = 2'(EPS_PH_LOAD);
      end
      EPS_PH_LOAD: begin
        // Caught once after release; later pin changes are ignored
        nxt_st.phase = 2'(EPS_PH_RUN);
        nxt_st.ready = 1'b1;
        if (st_ff.pins_s2 == EPS_PINS_ROMLESS0) begin
          nxt_st.opmode = 2'(EPS_OP_ROMLESS0);
          nxt_st.pin_function_code = EPS_RST_ROMLESS0[EPS_CFG_W-1:0];
        end else if (st_ff.pins_s2 == EPS_PINS_ROMLESS1) begin
          nxt_st.opmode = 2'(EPS_OP_ROMLESS1);
          nxt_st.pin_function_code = EPS_RST_ROMLESS1[EPS_CFG_W-1:0];
        end else if (st_ff.pins_s2 == EPS_PINS_SINGLE1) begin
          nxt_st.opmode = 2'(EPS_OP_SINGLE1);
          nxt_st.pin_function_code = EPS_RST_SINGLE1[EPS_CFG_W-1:0];
        end else begin
          // Unknown straps fall back to the safest mode: ports only
          nxt_st.opmode = 2'(EPS_OP_SINGLE0);
          nxt_st.pin_function_code = EPS_RST_SINGLE0[EPS_CFG_W-1:0];
        end
      end
      EPS_PH_RUN: begin
        // Rewrites are accepted; keeping the value fixed is software's job
        if (reg_wr_in && cfg_hit) begin
          nxt_st.pin_function_code = wr_merged[EPS_CFG_W-1:0];
        end
      end
      default: begin
        nxt_st.phase = 2'(EPS_PH_SYNC0);
      end
    endcase

    // Read data valid only in the cycle after the strobe
    nxt_st.rdata = EPS_UNMAPPED_DATA;
    if (reg_rd_in && cfg_hit) begin
      nxt_st.rdata = cfg_byte;
    end

    // Pin functions follow the registered code
    nxt_st.pinfn.port4 = expansion_on ? 8'hFF : 8'h00;
    nxt_st.pinfn.port5 = (expansion_on && !bus8) ? 8'hFF : 8'h00;
    nxt_st.pinfn.porta = expansion_on ? 8'hFF : 8'h00;
    nxt_st.pinfn.portb = {pair_ctrl[3:0], expansion_on ? 4'hF : 4'h0};
    nxt_st.pinfn.port6 = pair_ctrl[11:4];
    nxt_st.bus16 = expansion_on && !bus8;

    // External access decode; accesses before the run phase or with the pins in port mode are dropped
    nxt_st.acc = '0;
    if (acc_req_in && expansion_on && in_ext_map &&
        (eps_phase_t'(st_ff.phase) == EPS_PH_RUN)) begin
      nxt_st.acc.ext_cycle = 1'b1;
      nxt_st.acc.cs = cs_onehot;
      nxt_st.acc.addr = phys[EPS_EXT_ADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out = st_ff.rdata;
  assign ext_cycle_out = st_ff.acc.ext_cycle;
  assign chip_select_out = st_ff.acc.cs;
  assign external_address_lines_out = st_ff.acc.addr;
  assign bus16_out = st_ff.bus16;
  assign pin_function_out = st_ff.pinfn;
  assign operating_mode_out = st_ff.opmode;
  assign config_ready_out = st_ff.ready;

endmodule : eps_top

// file: eps_top_checker.sv
// Port checker for eps_top
`timescale 1ns/10ps
module eps_top_checker
  import eps_pkg::*;
#(
  parameter int CS_N = EPS_CS_N
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic acc_req_in,
  input wire logic [31:0] acc_addr_in,
  input wire logic ext_cycle_out,
  input wire logic [CS_N-1:0] chip_select_out,
  input wire logic bus16_out,
  input wire eps_pinfn_t pin_function_out,
  input wire logic [1:0] operating_mode_out,
  input wire logic config_ready_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Top address bits are dropped so every image decodes alike
  wire logic [25:0] pa = acc_addr_in[25:0];
  wire logic [2:0] blk = acc_addr_in[25:23];
  wire logic [1:0] om = operating_mode_out;
  wire logic rq = acc_req_in;
  property p_rsv; rq && pa >= 26'h1000000 && pa <= 26'h2FFFFFF |=> !ext_cycle_out; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved area decoded");
  property p_sc0; rq && om == 2'h2 && pa < 26'h0100000 |=> !ext_cycle_out; endproperty
  a_sc0: assert property (p_sc0) else $error("internal ROM decoded");
  property p_sc1; rq && om == 2'h3 && pa[25:20] == 6'h01 |=> !ext_cycle_out; endproperty
  a_sc1: assert property (p_sc1) else $error("relocated ROM decoded");
  property p_cs;
    ext_cycle_out |-> $past(rq) && chip_select_out == (CS_N'(1) << $past(blk));
  endproperty
  a_cs: assert property (p_cs) else $error("wrong block select");
  property p_b16; bus16_out == &pin_function_out.port5; endproperty
  a_b16: assert property (p_b16) else $error("bus width and port 5 disagree");
  property p_pair; |pin_function_out.port6 |-> pin_function_out.portb == 8'hFF; endproperty
  a_pair: assert property (p_pair) else $error("address pairs out of order");
  property p_rd; reg_rd_in && reg_addr_in[31:1] == 31'h7FFFF826 |=> reg_rdata_out[7:4] == 4'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("upper config bits not zero");
  property p_r0; $rose(config_ready_out) && om == 2'h0 |=> &pin_function_out && bus16_out;
  endproperty
  a_r0: assert property (p_r0) else $error("mode 0 reset not in bus mode");
  c_ext: cover property (ext_cycle_out);
  c_a23: cover property (pin_function_out.port6[7]);
  c_b8: cover property (config_ready_out && !bus16_out && pin_function_out.port4[0]);
endmodule : eps_top_checker

// file: eps_mem_model.sv
// External device model on the expansion bus: counts selected cycles
`timescale 1ns/10ps
module eps_mem_model (
  input wire logic mclk_in,
  input wire logic ext_cycle_in,
  input wire logic [7:0] cs_in,
  output logic [7:0] hits_out
);
  initial hits_out = 8'h00;
  // A cycle with no or several selects finds no device, so it is not counted
  always @(posedge mclk_in) if (ext_cycle_in && $onehot(cs_in)) hits_out <= hits_out + 8'h01;
endmodule : eps_mem_model

// file: eps_top_tb.sv
// Testbench for eps_top
`timescale 1ns/10ps
module eps_top_tb
  import eps_pkg::*;
;
  typedef struct packed {logic [3:0] pins; logic [7:0] cfg; logic [31:0] a; logic ext;} eps_row_t;
  logic mclk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, acc_req_in = 0;
  logic [3:0] operating_mode_pins_in = 4'h0;
  logic [31:0] reg_addr_in = 32'h0, acc_addr_in = 32'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_wmask_in = 8'h00, reg_rdata_out, chip_select_out, hits;
  logic ext_cycle_out, bus16_out, config_ready_out;
  logic [23:0] external_address_lines_out;
  logic [1:0] operating_mode_out;
  eps_pinfn_t pin_function_out;
  int mismatches = 0, n_checks = 0, nexp = 0;
  eps_row_t rows [10] = '{
    '{4'h0, 8'h07, 32'h00000010, 1'b1},
    '{4'h1, 8'h0F, 32'h03FFDFFF, 1'b1},
    '{4'h1, 8'h0F, 32'h01000000, 1'b0},
    '{4'hA, 8'h00, 32'h000FFFFF, 1'b0},
    '{4'hA, 8'h00, 32'h00100000, 1'b1},
    '{4'hA, 8'h00, 32'h03FFE000, 1'b0},
    '{4'hB, 8'h07, 32'h000FFFFF, 1'b1},
    '{4'hB, 8'h07, 32'h00100000, 1'b0},
    '{4'hB, 8'h07, 32'hFE2FFFFF, 1'b0},
    '{4'h0, 8'h07, 32'hFF800010, 1'b1}};
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  eps_top eps_top_inst (.mclk_in, .rst_in, .operating_mode_pins_in, .reg_addr_in, .reg_wdata_in,
    .reg_wmask_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .acc_req_in, .acc_addr_in,
    .ext_cycle_out, .chip_select_out, .external_address_lines_out, .bus16_out,
    .pin_function_out, .operating_mode_out, .config_ready_out);
  eps_mem_model eps_mem_model_inst (.mclk_in, .ext_cycle_in(ext_cycle_out),
    .cs_in(chip_select_out), .hits_out(hits));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Expected pin functions for a config value
  function automatic eps_pinfn_t pm(input logic [3:0] c);
    eps_pinfn_t f;
    f = '0;
    if (c[2:0] != 3'h0) begin
      f.port4 = 8'hFF;
      f.porta = 8'hFF;
      f.portb[3:0] = 4'hF;
      f.port5 = c[3] ? 8'h00 : 8'hFF;
    end
    f.portb[7:4] = {{2{c[2:0] >= 3}}, {2{c[2:0] >= 2}}};
    for (int j = 0; j < 4; j++) f.port6[2*j +: 2] = {2{c[2:0] >= j + 4}};
    return f;
  endfunction : pm
  task automatic reset(input logic [3:0] p);
    // Let the last access pulse reach the device model before reset clears it
    @(posedge mclk_in);
    rst_in <= 1'b1;
    operating_mode_pins_in <= p;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 8 && config_ready_out !== 1'b1; i++) begin
      @(posedge mclk_in);
      #1;
    end
    if (config_ready_out !== 1'b1) begin
      mismatches++;
      print_verdict;
    end
    @(posedge mclk_in);
    #1;
  endtask : reset
  task automatic wr(input logic [7:0] d, input logic [7:0] m);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= 32'hFFFFF04C;
    reg_wdata_in <= d;
    reg_wmask_in <= m;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    // Pins follow one cycle after the register
    @(posedge mclk_in);
    #1;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd
  task automatic acc(input logic [31:0] a);
    @(posedge mclk_in);
    acc_req_in <= 1'b1;
    acc_addr_in <= a;
    @(posedge mclk_in);
    acc_req_in <= 1'b0;
    #1;
  endtask : acc
  initial begin
    #1000000;
    mismatches++;
    print_verdict;
  end
  initial begin
    logic [7:0] v;
    eps_row_t r;
    foreach (rows[i]) begin
      r = rows[i];
      reset(r.pins);
      chk("mode", {r.pins[3], r.pins[0]}, operating_mode_out);
      rd(32'hFFFFF04C, v);
      chk("cfg reset", r.cfg, v);
      chk("pins", pm(r.cfg[3:0]), pin_function_out);
      chk("bus16", r.cfg[2:0] != 3'h0 && !r.cfg[3], bus16_out);
      if (r.cfg == 8'h00) wr(8'h07, 8'hFF);
      acc(r.a);
      chk("ext", r.ext, ext_cycle_out);
      chk("cs", r.ext ? 8'h01 << r.a[25:23] : 8'h00, chip_select_out);
      chk("addr", r.ext ? r.a[23:0] : 24'h0, external_address_lines_out);
      nexp += r.ext;
      $display("row %0d done", i);
    end
    @(posedge mclk_in);
    #1;
    chk("hits", nexp, hits);
    for (int c = 0; c < 16; c++) begin
      wr({4'hF, 4'(c)}, 8'hFF);
      chk("pin map", pm(4'(c)), pin_function_out);
      rd(32'hFFFFF04D, v);
      chk("cfg read", {4'h0, 4'(c)}, v);
    end
    $display("code sweep done");
    wr(8'h00, 8'h08);
    rd(32'hFFFFF04C, v);
    chk("bit op", 8'h07, v);
    rd(32'hFFFFF04E, v);
    chk("unmapped", 8'h00, v);
    $display("register tests done");
    print_verdict;
  end
endmodule : eps_top_tb
bind eps_top eps_top_checker #(.CS_N(CS_N)) eps_top_checker_inst (.mclk_in, .rst_in,
  .reg_addr_in, .reg_rd_in, .reg_rdata_out, .acc_req_in, .acc_addr_in, .ext_cycle_out,
  .chip_select_out, .bus16_out, .pin_function_out, .operating_mode_out, .config_ready_out);
